// ===== uiid_pkg.sv
// Package of constants and types for the identifier register bank
// Notes on behaviour
// - Vendor identifier low byte held in 8 bits; default replaceable by configuration.
// - Vendor identifier high byte held separately; both form 16-bit vendor identifier.
// - Product low byte reported as is for SuperSpeed, bit 1 inverted for 2.0.
// - Product identifier high byte held in 8 bits with replaceable default.
// - Loaded or written values used when any of the four vendor and product bytes is non-zero.
// - All-zero load falls back to non-zero one-time value, else built-in default.
// - EEPROM load abandoned, falling back to one-time value or default, unless first byte matches marker.
// - SMBus mode accepts writes only in block protocol; read-back does not depend on protocol.
package uiid_pkg;
   localparam logic [7:0] UIID_OFF_MARKER  = 8'h00;
   localparam logic [7:0] UIID_OFF_VID_LO  = 8'h01;
   localparam logic [7:0] UIID_OFF_VID_HI  = 8'h02;
   localparam logic [7:0] UIID_OFF_PID_LO  = 8'h03;
   localparam logic [7:0] UIID_OFF_PID_HI  = 8'h04;
   localparam logic [7:0] UIID_MARKER_VAL  = 8'h55;
   localparam logic [7:0] UIID_LEGACY_FLIP = 8'h02;
   // Built-in defaults; arbitrary neutral values
   localparam logic [7:0] UIID_DEF_VID_LO  = 8'h34;
   localparam logic [7:0] UIID_DEF_VID_HI  = 8'h12;
   localparam logic [7:0] UIID_DEF_PID_LO  = 8'h78;
   localparam logic [7:0] UIID_DEF_PID_HI  = 8'h56;
   typedef enum logic [1:0] {UIID_SRC_DEF, UIID_SRC_OTP, UIID_SRC_EXT} uiid_src_t;
   typedef enum logic [1:0] {UIID_IDLE, UIID_LOADING, UIID_SKIP, UIID_DONE} uiid_state_t;
endpackage

// ===== uiid_identity_regs.sv
// Identifier register bank with source resolution after configuration load
module uiid_identity_regs
   import uiid_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       cfgEepromMode,
   input  wire logic       cfgWrite,
   input  wire logic [7:0] cfgAddr,
   input  wire logic [7:0] cfgWrData,
   input  wire logic       cfgBlockProto,
   input  wire logic       cfgDone,
   input  wire logic [7:0] cfgRdAddr,
   output logic      [7:0] cfgRdData,
   input  wire logic [7:0] otpVidLo,
   input  wire logic [7:0] otpVidHi,
   input  wire logic [7:0] otpPidLo,
   input  wire logic [7:0] otpPidHi,
   output logic     [15:0] vendorIdentifier,
   output logic     [15:0] productIdentifierSs,
   output logic     [15:0] productIdentifierHs,
   output logic            identValid,
   output uiid_src_t       identSource
);
   uiid_state_t state;
   logic [7:0]  extVidLo, extVidHi, extPidLo, extPidHi;
   logic        firstByteSeen;

   // Writes accepted only in block protocol when on SMBus; EEPROM needs marker
   wire         busAllowed  = cfgEepromMode | cfgBlockProto;
   wire         markerWrite = cfgWrite & busAllowed & (cfgAddr == UIID_OFF_MARKER);
   wire         markerBad   = markerWrite & cfgEepromMode & (cfgWrData != UIID_MARKER_VAL);
   wire         idWrite     = cfgWrite & busAllowed & (state == UIID_LOADING)
                              & ~(cfgEepromMode & ~firstByteSeen);
   wire         extZero     = ({extVidLo, extVidHi, extPidLo, extPidHi} == 32'h0);
   wire         otpZero     = ({otpVidLo, otpVidHi, otpPidLo, otpPidHi} == 32'h0);
   wire uiid_src_t next_src = !extZero ? UIID_SRC_EXT :
                              !otpZero ? UIID_SRC_OTP : UIID_SRC_DEF;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state         <= UIID_LOADING;
         firstByteSeen <= 1'b0;
      end else begin
         case (state)
            UIID_LOADING: begin
               if (markerBad) begin
                  state <= UIID_SKIP;
               end else if (cfgDone) begin
                  state <= UIID_DONE;
               end
               if (markerWrite) begin
                  firstByteSeen <= 1'b1;
               end
            end
            UIID_SKIP: begin
               if (cfgDone) begin
                  state <= UIID_DONE;
               end
            end
            UIID_DONE: state <= UIID_DONE;
            default:   state <= UIID_LOADING;
         endcase
      end
   end

   // External staging bytes; cleared so a skipped load falls back to one-time value or defaults
   always_ff @(posedge clk_sys) begin
      if (sys_rst || markerBad) begin
         extVidLo <= 8'h00;
         extVidHi <= 8'h00;
         extPidLo <= 8'h00;
         extPidHi <= 8'h00;
      end else if (idWrite) begin
         if (cfgAddr == UIID_OFF_VID_LO) extVidLo <= cfgWrData;
         if (cfgAddr == UIID_OFF_VID_HI) extVidHi <= cfgWrData;
         if (cfgAddr == UIID_OFF_PID_LO) extPidLo <= cfgWrData;
         if (cfgAddr == UIID_OFF_PID_HI) extPidHi <= cfgWrData;
      end
   end

   // Resolution happens once; outputs frozen until reset
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         vendorIdentifier    <= {UIID_DEF_VID_HI, UIID_DEF_VID_LO};
         productIdentifierSs <= {UIID_DEF_PID_HI, UIID_DEF_PID_LO};
         productIdentifierHs <= {UIID_DEF_PID_HI, UIID_DEF_PID_LO ^ UIID_LEGACY_FLIP};
         identValid          <= 1'b0;
         identSource         <= UIID_SRC_DEF;
      end else if (state != UIID_DONE && cfgDone) begin
         identValid  <= 1'b1;
         identSource <= next_src;
         case (next_src)
            UIID_SRC_EXT: begin
               vendorIdentifier    <= {extVidHi, extVidLo};
               productIdentifierSs <= {extPidHi, extPidLo};
               productIdentifierHs <= {extPidHi, extPidLo ^ UIID_LEGACY_FLIP};
            end
            UIID_SRC_OTP: begin
               vendorIdentifier    <= {otpVidHi, otpVidLo};
               productIdentifierSs <= {otpPidHi, otpPidLo};
               productIdentifierHs <= {otpPidHi, otpPidLo ^ UIID_LEGACY_FLIP};
            end
            default: begin
               vendorIdentifier    <= {UIID_DEF_VID_HI, UIID_DEF_VID_LO};
               productIdentifierSs <= {UIID_DEF_PID_HI, UIID_DEF_PID_LO};
               productIdentifierHs <= {UIID_DEF_PID_HI, UIID_DEF_PID_LO ^ UIID_LEGACY_FLIP};
            end
         endcase
      end
   end

   // Read-back shows the values in use
   always_comb begin
      case (cfgRdAddr)
         UIID_OFF_VID_LO: cfgRdData = vendorIdentifier[7:0];
         UIID_OFF_VID_HI: cfgRdData = vendorIdentifier[15:8];
         UIID_OFF_PID_LO: cfgRdData = productIdentifierSs[7:0];
         UIID_OFF_PID_HI: cfgRdData = productIdentifierSs[15:8];
         default:         cfgRdData = 8'h00;
      endcase
   end

   a_legacy_flip: assert property (@(posedge clk_sys) disable iff (sys_rst)
      productIdentifierHs == (productIdentifierSs ^ {8'h00, UIID_LEGACY_FLIP}))
      else $error("legacy product low byte not flipped");
   a_bad_marker_defaults: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == UIID_SKIP && cfgDone && otpZero) |=> vendorIdentifier ==
      {UIID_DEF_VID_HI, UIID_DEF_VID_LO})
      else $error("bad marker did not keep defaults");
   a_ext_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == UIID_LOADING && cfgDone && !extZero) |=>
      identSource == UIID_SRC_EXT && vendorIdentifier == $past({extVidHi, extVidLo}))
      else $error("external value not used");
   a_otp_fallback: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state != UIID_DONE && cfgDone && extZero && !otpZero) |=>
      identSource == UIID_SRC_OTP)
      else $error("one-time value not used");
   a_hold_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == UIID_DONE) |=> $stable(vendorIdentifier) && $stable(productIdentifierSs))
      else $error("identifier changed after resolution");
   a_no_other_proto: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cfgWrite && !cfgEepromMode && !cfgBlockProto && !markerBad) |=>
      $stable(extVidLo) && $stable(extPidHi))
      else $error("non-block protocol accepted");
   a_vid_high_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (idWrite && cfgAddr == UIID_OFF_VID_HI && !markerBad) |=> extVidHi == $past(cfgWrData))
      else $error("vendor high byte not stored");
   a_pid_high_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (idWrite && cfgAddr == UIID_OFF_PID_HI && !markerBad) |=> extPidHi == $past(cfgWrData))
      else $error("product high byte not stored");
   a_vid_low_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cfgRdAddr == UIID_OFF_VID_LO) |-> cfgRdData == vendorIdentifier[7:0])
      else $error("vendor low byte read mismatch");


   // Resolution outcome and its persistence
   a_valid_after_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state != UIID_DONE && cfgDone)
      |=> identValid)
      else $error("valid flag not raised after load");
   a_valid_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
      identValid
      |=> identValid)
      else $error("valid flag dropped without reset");
   a_no_late_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == UIID_DONE)
      |-> !idWrite)
      else $error("staging written after resolution");

   // Source selection, value by value
   a_ext_product: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == UIID_LOADING && cfgDone && !extZero)
      |=> productIdentifierSs == $past({extPidHi, extPidLo}))
      else $error("external product value not used");
   a_ext_legacy: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == UIID_LOADING && cfgDone && !extZero)
      |=> productIdentifierHs == $past({extPidHi, extPidLo ^ UIID_LEGACY_FLIP}))
      else $error("legacy product value not derived");
   a_otp_values: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state != UIID_DONE && cfgDone && extZero && !otpZero)
      |=> vendorIdentifier == $past({otpVidHi, otpVidLo}))
      else $error("one-time vendor value not used");
   a_def_fallback: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state != UIID_DONE && cfgDone && extZero && otpZero)
      |=> identSource == UIID_SRC_DEF && productIdentifierSs == {UIID_DEF_PID_HI, UIID_DEF_PID_LO})
      else $error("built-in default not used");

   // Marker handling; a bad marker must leave nothing staged
   a_skip_enter: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == UIID_LOADING && markerBad)
      |=> state == UIID_SKIP)
      else $error("bad marker did not abandon load");
   a_skip_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
      markerBad
      |=> extZero)
      else $error("staging kept after bad marker");
   a_skip_no_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state == UIID_SKIP)
      |-> !idWrite)
      else $error("byte stored after abandoned load");
   a_marker_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cfgEepromMode && !firstByteSeen)
      |-> !idWrite)
      else $error("byte stored before marker");

   // Staging of the low bytes and read-back of the high byte
   a_vid_low_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (idWrite && cfgAddr == UIID_OFF_VID_LO && !markerBad)
      |=> extVidLo == $past(cfgWrData))
      else $error("vendor low byte not stored");
   a_pid_low_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (idWrite && cfgAddr == UIID_OFF_PID_LO && !markerBad)
      |=> extPidLo == $past(cfgWrData))
      else $error("product low byte not stored");
   a_pid_high_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cfgRdAddr == UIID_OFF_PID_HI)
      |-> cfgRdData == productIdentifierSs[15:8])
      else $error("product high byte read mismatch");

   c_ext_used: cover property (@(posedge clk_sys) identSource == UIID_SRC_EXT && identValid);
   c_otp_used: cover property (@(posedge clk_sys) identSource == UIID_SRC_OTP && identValid);
   c_skip_load: cover property (@(posedge clk_sys) state == UIID_SKIP);
   c_def_used: cover property (@(posedge clk_sys)
      identSource == UIID_SRC_DEF && identValid);
   c_late_write: cover property (@(posedge clk_sys)
      state == UIID_DONE && cfgWrite);
endmodule

// ===== uiid_cfg_loader.sv
// Behavioural configuration source that streams one image into the bank
module uiid_cfg_loader (
   input  wire logic        clk_sys,
   input  wire logic        startLoad,
   input  wire logic        slowPace,
   input  wire logic [39:0] imageBytes,
   output logic             cfgWrite,
   output logic      [7:0]  cfgAddr,
   output logic      [7:0]  cfgWrData,
   output logic             cfgDone,
   output logic             loadBusy
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {cfgWrite, cfgDone, loadBusy, cfgAddr, cfgWrData} = {3'b000, 16'hffff};
      forever begin
         @(posedge clk_sys iff startLoad);
         #1 loadBusy = 1'b1;
         // Marker first, then both vendor and both product bytes
         for (int i = 0; i < 5; i++) begin
            cfgWrite = 1'b1;
            cfgAddr = 8'(i);
            cfgWrData = imageBytes[8*i +: 8];
            @(posedge clk_sys);
            #1;
            // Released lines show the inverse so a stale byte never matches
            if (slowPace) begin
               {cfgWrite, cfgAddr, cfgWrData} = {1'b0, ~cfgAddr, ~cfgWrData};
               repeat (3) @(posedge clk_sys);
               #1;
            end
         end
         {cfgWrite, cfgDone, cfgAddr, cfgWrData} = {2'b01, 8'h5a, 8'ha5};
         @(posedge clk_sys);
         #1 {cfgDone, loadBusy} = 2'b00;
      end
   end
endmodule

// ===== uiid_identity_regs_bench.sv
// Self-checking bench for the identifier register bank
module uiid_identity_regs_bench
   import uiid_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, sys_rst, cfgEepromMode, cfgBlockProto, startLoad, slowPace, identValid;
   logic cfgWrite, cfgDone, loadBusy;
   logic [7:0] cfgAddr, cfgWrData, cfgRdAddr, cfgRdData;
   logic [31:0] otpBytes;
   logic [39:0] imageBytes;
   logic [15:0] vendorIdentifier, productIdentifierSs, productIdentifierHs;
   uiid_src_t identSource;
   int mismatches, total_checks;
   uiid_identity_regs uiid_identity_regs_inst (.clk_sys, .sys_rst, .cfgEepromMode, .cfgWrite,
      .cfgAddr, .cfgWrData, .cfgBlockProto, .cfgDone, .cfgRdAddr, .cfgRdData,
      .otpVidLo(otpBytes[7:0]), .otpVidHi(otpBytes[15:8]), .otpPidLo(otpBytes[23:16]),
      .otpPidHi(otpBytes[31:24]), .vendorIdentifier, .productIdentifierSs,
      .productIdentifierHs, .identValid, .identSource);
   uiid_cfg_loader uiid_cfg_loader_inst (.clk_sys, .startLoad, .slowPace, .imageBytes,
      .cfgWrite, .cfgAddr, .cfgWrData, .cfgDone, .loadBusy);
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
      check8({what, " hi"}, exp[15:8], got[15:8]);
      check8({what, " lo"}, exp[7:0], got[7:0]);
   endtask
   task automatic load_image(input logic [39:0] img);
      int n;
      imageBytes = img;
      startLoad = 1'b1;
      @(posedge clk_sys);
      #1 startLoad = 1'b0;
      n = 0;
      repeat (2) @(posedge clk_sys);
      while (loadBusy !== 1'b0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      #1;
   endtask
   task automatic run_case(input string name, input logic ee, blk, slow, input logic [31:0] otp,
      input logic [39:0] img, input logic [15:0] vendor_identifier, product_identifier, input logic [7:0] src);
      logic [47:0] map;
      map = {8'h00, product_identifier, vendor_identifier, 8'h00};
      @(posedge clk_sys);
      #1 {sys_rst, cfgEepromMode, cfgBlockProto, slowPace, otpBytes} = {1'b1, ee, blk, slow, otp};
      repeat (2) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      check8("valid early", 8'h00, {7'h0, identValid});
      check16("reset vendor", {UIID_DEF_VID_HI, UIID_DEF_VID_LO}, vendorIdentifier);
      load_image(img);
      check16("vendor", vendor_identifier, vendorIdentifier);
      check16("product ss", product_identifier, productIdentifierSs);
      check16("product hs", product_identifier ^ {8'h00, UIID_LEGACY_FLIP}, productIdentifierHs);
      check8("source", src, {6'h0, identSource});
      check8("valid", 8'h01, {7'h0, identValid});
      for (int a = 0; a < 6; a++) begin
         cfgRdAddr = 8'(a);
         #0.5 check8("readback", map[8*a +: 8], cfgRdData);
      end
      // A second load without reset must leave the result alone
      load_image(~img);
      check16("held vendor", vendor_identifier, vendorIdentifier);
      check16("held product", product_identifier, productIdentifierSs);
      $display("test %s done", name);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (3000) @(posedge clk_sys);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      {sys_rst, cfgEepromMode, cfgBlockProto, startLoad, slowPace} = 5'b10000;
      {cfgRdAddr, otpBytes, imageBytes} = '0;
      run_case("defaults", 0, 1, 0, 32'h0, 40'h0, 16'h1234, 16'h5678, 8'h00);
      run_case("otp", 0, 1, 0, 32'ha1b2c3d4, 40'h0, 16'hc3d4, 16'ha1b2, 8'h01);
      run_case("eeprom", 1, 0, 1, 32'ha1b2c3d4, 40'h9abcdef055, 16'hdef0, 16'h9abc, 8'h02);
      run_case("marker", 1, 1, 0, 32'ha1b2c3d4, 40'h9abcdef054, 16'hc3d4, 16'ha1b2, 8'h01);
      run_case("marker def", 1, 1, 0, 32'h0, 40'h9abcdef054, 16'h1234, 16'h5678, 8'h00);
      run_case("nonblock", 0, 0, 0, 32'h0, 40'h9abcdef055, 16'h1234, 16'h5678, 8'h00);
      run_case("one byte", 0, 1, 0, 32'h0, 40'h0000000100, 16'h0001, 16'h0000, 8'h02);
      tally_and_finish();
   end
endmodule
